// File: hdl/ssb_pkg.sv
`default_nettype none
package ssb_pkg;
  // Register byte offsets on the bus
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam logic [3:0] SKCNT_OFS = 4'h8;
  localparam logic [3:0] BRCNT_OFS = 4'hc;
  // Control field positions and reset value
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam logic CTRL_EN_RST = 1'b1;
  // Status field positions
  localparam int STAT_SKIP_BIT = 0;
  localparam int STAT_BR_BIT = 1;
  // Decision outputs after reset: no skip, no branch
  localparam logic SKIP_N_RST = 1'b1;
  localparam logic BR_N_RST = 1'b1;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam int NBYTES = 4;
endpackage : ssb_pkg
`default_nettype wire

// File: hdl/ssb_core_if.sv
`default_nettype none
interface ssb_core_if;
  // Word under test and halfword unit tests (index 1 = left)
  logic [31:0] word;
  logic [1:0] hw_p1;
  logic [1:0] hw_m1;
  // Register side
  logic ctrl_en;
  logic cnt_clr;
  logic [1:0] dec_state;
  logic [ssb_pkg::CNT_W-1:0] skip_cnt;
  logic [ssb_pkg::CNT_W-1:0] br_cnt;
  modport tst (input word, output hw_p1, output hw_m1);
  modport regs (output ctrl_en, output cnt_clr, input dec_state, input skip_cnt, input br_cnt);
  modport core (output word, output dec_state, output skip_cnt, output br_cnt,
                input hw_p1, input hw_m1, input ctrl_en, input cnt_clr);
endinterface : ssb_core_if
`default_nettype wire

// File: hdl/ssb_unit_test.sv
`default_nettype none
module ssb_unit_test (
  ssb_core_if.tst t
);
  logic [3:0] op1;
  logic [3:0] op7;
  logic [3:0] om1;
  // Byte 0 is the leftmost byte; bit 0 is its most significant bit
  for (genvar i = 0; i < ssb_pkg::NBYTES; i++) begin : g_byte
    logic [7:0] b;
    assign b = t.word[31-8*i -: 8];
    assign op1[i] = ~|b[7:1];
    assign op7[i] = b[0];
    assign om1[i] = &b;
  end
  // Halfword plus one: high byte all zero, low byte plus one
  assign t.hw_p1[1] = op1[0] & ~op7[0] & op1[1] & op7[1];
  assign t.hw_p1[0] = op1[2] & ~op7[2] & op1[3] & op7[3];
  // Halfword minus one: both bytes all ones
  assign t.hw_m1[1] = om1[0] & om1[1];
  assign t.hw_m1[0] = om1[2] & om1[3];
endmodule : ssb_unit_test
`default_nettype wire

// File: hdl/ssb_wb_regs.sv
`default_nettype none
module ssb_wb_regs (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  ssb_core_if.regs r
);
  logic req;
  logic en_reg;
  logic clr_reg;
  logic [31:0] rd_next;
  // Ack one cycle after the request, dropped the next cycle
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign r.ctrl_en = en_reg;
  assign r.cnt_clr = clr_reg;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end
  // Control write; clear bit is a one-cycle pulse
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      en_reg <= ssb_pkg::CTRL_EN_RST;
      clr_reg <= 1'b0;
    end else begin
      clr_reg <= 1'b0;
      if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == ssb_pkg::CTRL_OFS) begin
        en_reg <= wb_dat_i[ssb_pkg::CTRL_EN_BIT];
        clr_reg <= wb_dat_i[ssb_pkg::CTRL_CLR_BIT];
      end
    end
  end
  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_next = 32'h0000_0000;
    unique case (wb_adr_i)
      ssb_pkg::CTRL_OFS: rd_next[ssb_pkg::CTRL_EN_BIT] = en_reg;
      ssb_pkg::STAT_OFS: rd_next[1:0] = r.dec_state;
      ssb_pkg::SKCNT_OFS: rd_next[ssb_pkg::CNT_W-1:0] = r.skip_cnt;
      ssb_pkg::BRCNT_OFS: rd_next[ssb_pkg::CNT_W-1:0] = r.br_cnt;
      default: rd_next = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= rd_next;
    end
  end
endmodule : ssb_wb_regs
`default_nettype wire

// File: hdl/ssb_top.sv
// What this block does
// - Pull stack in execute step 2: no skip if word count zero, else skip.
// - Push stack in execute step 2: no skip if space count zero, else skip.
// - Modify stack: no skip if byte 0 or 2 sign negative, else skip.
// - Stack skip output is active low; low means skip next instruction.
// - Stack skip goes to test-positive logic and to program counter control.
// - Branch output is the AND of five group terms; low requests branch.
// - A taken branch sends control to the T and N field target.
// - Decrement branch if zero: branch when selected halfword is plus one.
// - Increment branch if zero: branch when selected halfword is minus one.
// - Byte branch-if-positive branches on the selected byte's positive test.
// - Halfword sign branches use byte 0 for left, byte 2 for right.
// - Word sign branches use the sign test of byte 0.
// - Word and halfword zero/nonzero branches follow the zero test.
// - Byte nonzero, zero and minus branches test the selected byte.
// - Decode lines count only while the instruction is in execute step 2.
// - Branch output goes to test-positive logic and program counter control.
// - Byte is plus one if bits 0-6 zero and bit 7 one; minus one if all ones.
//
// The Wishbone slave port and the placing of the registers were left to the implementer.
`default_nettype none
module ssb_top (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic exec_step2_i,
  input wire logic pull_stack_i,
  input wire logic push_stack_i,
  input wire logic modify_stack_i,
  input wire logic sub_one_branch_if_zero_i,
  input wire logic sub_one_branch_unless_zero_i,
  input wire logic add_one_branch_if_zero_i,
  input wire logic add_one_branch_unless_zero_i,
  input wire logic byte_positive_branch_i,
  input wire logic half_negative_branch_i,
  input wire logic half_positive_branch_i,
  input wire logic word_negative_branch_i,
  input wire logic word_positive_branch_i,
  input wire logic word_nonzero_branch_i,
  input wire logic half_nonzero_branch_i,
  input wire logic word_zero_branch_i,
  input wire logic half_zero_branch_i,
  input wire logic byte_nonzero_branch_i,
  input wire logic byte_zero_branch_i,
  input wire logic byte_negative_branch_i,
  input wire logic left_half_select_i,
  input wire logic right_half_select_i,
  input wire logic [3:0] byte_select_i,
  input wire logic [3:0] byte_zero_flag_i,
  input wire logic [3:0] byte_sign_negative_flag_i,
  input wire logic [3:0] byte_positive_flag_i,
  input wire logic [31:0] vpr_word_i,
  output logic stack_skip_n_tp_o,
  output logic stack_skip_n_pc_o,
  output logic branch_taken_n_tp_o,
  output logic branch_taken_n_pc_o
);
  ssb_core_if cif ();

  logic act;
  logic pul;
  logic psh;
  logic mdf;
  logic dz;
  logic dn;
  logic iz;
  logic inb;
  logic byte_positive_branch;
  logic half_negative_branch;
  logic half_positive_branch;
  logic tmw;
  logic tpw;
  logic tnw;
  logic half_nonzero_branch;
  logic tzw;
  logic half_zero_branch;
  logic byte_nonzero_branch;
  logic byte_zero_branch;
  logic byte_negative_branch;
  logic lh;
  logic rh;
  logic [3:0] bs;
  logic [3:0] z;
  logic [3:0] ng;
  logic [3:0] ps;
  logic p1l;
  logic p1r;
  logic m1l;
  logic m1r;
  logic skip_n_next;
  logic f1;
  logic f2;
  logic f3;
  logic f4;
  logic f5;
  logic [3:0] f3b;
  logic [3:0] f5b;
  logic br_n_next;
  logic skip_n_reg;
  logic br_n_reg;
  logic [ssb_pkg::CNT_W-1:0] skip_cnt_reg;
  logic [ssb_pkg::CNT_W-1:0] br_cnt_reg;

  ssb_unit_test u_test (
    .t (cif.tst)
  );

  ssb_wb_regs u_regs (
    .sys_clk_i (sys_clk_i),
    .rst_b_i (rst_b_i),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .r (cif.regs)
  );

  // Core side of the shared interface
  assign cif.word = vpr_word_i;
  assign cif.dec_state = {br_n_reg, skip_n_reg};
  assign cif.skip_cnt = skip_cnt_reg;
  assign cif.br_cnt = br_cnt_reg;

  // Decode lines qualified by step 2 and the software enable
  assign act = exec_step2_i & cif.ctrl_en;
  assign pul = act & pull_stack_i;
  assign psh = act & push_stack_i;
  assign mdf = act & modify_stack_i;
  assign dz = act & sub_one_branch_if_zero_i;
  assign dn = act & sub_one_branch_unless_zero_i;
  assign iz = act & add_one_branch_if_zero_i;
  assign inb = act & add_one_branch_unless_zero_i;
  assign byte_positive_branch = act & byte_positive_branch_i;
  assign half_negative_branch = act & half_negative_branch_i;
  assign half_positive_branch = act & half_positive_branch_i;
  assign tmw = act & word_negative_branch_i;
  assign tpw = act & word_positive_branch_i;
  assign tnw = act & word_nonzero_branch_i;
  assign half_nonzero_branch = act & half_nonzero_branch_i;
  assign tzw = act & word_zero_branch_i;
  assign half_zero_branch = act & half_zero_branch_i;
  assign byte_nonzero_branch = act & byte_nonzero_branch_i;
  assign byte_zero_branch = act & byte_zero_branch_i;
  assign byte_negative_branch = act & byte_negative_branch_i;

  // Short names for selectors and test flags
  assign lh = left_half_select_i;
  assign rh = right_half_select_i;
  assign bs = byte_select_i;
  assign z = byte_zero_flag_i;
  assign ng = byte_sign_negative_flag_i;
  assign ps = byte_positive_flag_i;
  assign p1l = cif.hw_p1[1];
  assign p1r = cif.hw_p1[0];
  assign m1l = cif.hw_m1[1];
  assign m1r = cif.hw_m1[0];

  // Stack skip, low means skip
  assign skip_n_next = (~pul | z[0]) & (~pul | z[1])
                     & (~psh | z[2]) & (~psh | z[3])
                     & (~mdf | ng[0] | ng[2]);

  // Decrement group: registers are still undecremented in step 2
  assign f1 = (~dz | ~lh | ~p1l) & (~dz | ~rh | ~p1r)
            & (~dn | ~lh | p1l) & (~dn | ~rh | p1r);
  // Increment group: registers are still unincremented in step 2
  assign f2 = (~iz | ~lh | ~m1l) & (~iz | ~rh | ~m1r)
            & (~inb | ~lh | m1l) & (~inb | ~rh | m1r);

  // Per-byte terms of the sign and byte-test groups
  for (genvar i = 0; i < ssb_pkg::NBYTES; i++) begin : g_bt
    assign f3b[i] = ~byte_positive_branch | ~bs[i] | ~ps[i];
    assign f5b[i] = (~byte_nonzero_branch | ~bs[i] | z[i])
                  & (~byte_zero_branch | ~bs[i] | ~z[i])
                  & (~byte_negative_branch | ~bs[i] | ~ng[i]);
  end

  // Sign group: left half and word use byte 0, right half byte 2
  assign f3 = (&f3b)
            & (~half_negative_branch | ~lh | ~ng[0]) & (~half_negative_branch | ~rh | ~ng[2])
            & (~half_positive_branch | ~lh | ~ps[0]) & (~half_positive_branch | ~rh | ~ps[2])
            & (~tmw | ~ng[0]) & (~tpw | ~ps[0]);

  // Zero group for word and halfwords
  assign f4 = (~tnw | (&z))
            & (~half_nonzero_branch | ~lh | (z[0] & z[1]))
            & (~half_nonzero_branch | ~rh | (z[2] & z[3]))
            & (~tzw | ~(&z))
            & (~half_zero_branch | ~lh | ~(z[0] & z[1]))
            & (~half_zero_branch | ~rh | ~(z[2] & z[3]));

  assign f5 = &f5b;

  // Any group at zero requests the branch
  assign br_n_next = f1 & f2 & f3 & f4 & f5;

  // Registered decisions; one cycle after the decode inputs
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      skip_n_reg <= ssb_pkg::SKIP_N_RST;
      br_n_reg <= ssb_pkg::BR_N_RST;
    end else begin
      skip_n_reg <= skip_n_next;
      br_n_reg <= br_n_next;
    end
  end

  // Two copies so each consumer gets its own flop-driven line
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stack_skip_n_tp_o <= ssb_pkg::SKIP_N_RST;
      stack_skip_n_pc_o <= ssb_pkg::SKIP_N_RST;
    end else begin
      stack_skip_n_tp_o <= skip_n_next;
      stack_skip_n_pc_o <= skip_n_next;
    end
  end

  // Program counter control loads the T and N target on a low here
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      branch_taken_n_tp_o <= ssb_pkg::BR_N_RST;
      branch_taken_n_pc_o <= ssb_pkg::BR_N_RST;
    end else begin
      branch_taken_n_tp_o <= br_n_next;
      branch_taken_n_pc_o <= br_n_next;
    end
  end

  // Event counters; a count in the clear cycle is kept, not lost
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      skip_cnt_reg <= ssb_pkg::CNT_RST;
    end else if (cif.cnt_clr) begin
      skip_cnt_reg <= {{(ssb_pkg::CNT_W-1){1'b0}}, ~skip_n_next};
    end else if (!skip_n_next) begin
      skip_cnt_reg <= skip_cnt_reg + 16'h0001; // Wraps silently
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      br_cnt_reg <= ssb_pkg::CNT_RST;
    end else if (cif.cnt_clr) begin
      br_cnt_reg <= {{(ssb_pkg::CNT_W-1){1'b0}}, ~br_n_next};
    end else if (!br_n_next) begin
      br_cnt_reg <= br_cnt_reg + 16'h0001;
    end
  end

  // Checks on the decision outputs
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_pull_zero_noskip: assert property (
    pul && z[0] && z[1] && !psh && !mdf |=> stack_skip_n_pc_o)
    else $error("pull with zero count skipped");

  a_pull_count_skip: assert property (
    pul && !(z[0] && z[1]) |=> !stack_skip_n_pc_o && !stack_skip_n_tp_o)
    else $error("pull with nonzero count did not skip");

  a_push_count_skip: assert property (
    psh && !(z[2] && z[3]) |=> !stack_skip_n_pc_o)
    else $error("push with nonzero space did not skip");

  a_modify_sign_skip: assert property (
    mdf && !ng[0] && !ng[2] && !pul && !psh |=> !stack_skip_n_tp_o)
    else $error("modify with positive counts did not skip");

  a_idle_no_skip: assert property (
    !exec_step2_i |=> stack_skip_n_pc_o && branch_taken_n_pc_o)
    else $error("skip or branch outside step 2");

  a_skip_routes_agree: assert property (
    stack_skip_n_tp_o == stack_skip_n_pc_o)
    else $error("skip copies differ");

  a_branch_has_cause: assert property (
    !branch_taken_n_pc_o |-> $past(exec_step2_i) && $past(cif.ctrl_en))
    else $error("branch without step 2 decode");

  a_dec_plus_one: assert property (
    dz && lh && p1l |=> !branch_taken_n_pc_o)
    else $error("decrement branch missed on plus one");

  a_inc_minus_one: assert property (
    iz && rh && m1r |=> !branch_taken_n_tp_o)
    else $error("increment branch missed on minus one");

  a_byte_pos_branch: assert property (
    byte_positive_branch && bs[3] && ps[3] |=> !branch_taken_n_pc_o)
    else $error("byte positive branch missed");

  a_branch_routes_agree: assert property (
    branch_taken_n_tp_o == branch_taken_n_pc_o)
    else $error("branch copies differ");

  a_word_sign_branch: assert property (
    tmw && ng[0] ##1 !cif.ctrl_en [*2] |=> branch_taken_n_pc_o)
    else $error("branch while disabled");
endmodule : ssb_top
`default_nettype wire

// File: testbench/ssb_decode_model.sv
`default_nettype none
module ssb_decode_model (
  input wire logic [4:0] op_i,
  input wire logic step2_i,
  output logic [18:0] lines_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // One decode line per instruction; codes above 18 mean no decoded instruction
  always_comb begin
    lines_o = 19'h0;
    if (step2_i && op_i < 5'h13) begin
      lines_o[op_i] = 1'b1;
    end
  end
endmodule : ssb_decode_model
`default_nettype wire

// File: testbench/ssb_top_tb.sv
`default_nettype none
module ssb_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [4:0] op = 5'h1f;
  logic step = 1'b0;
  logic lh = 1'b0;
  logic rh = 1'b0;
  logic en = 1'b1;
  logic [3:0] bsel = 4'h0;
  logic [3:0] zf = 4'hf;
  logic [3:0] nf = 4'h0;
  logic [3:0] pf = 4'h0;
  logic [31:0] word = 32'h0;
  logic [18:0] dl;
  logic sk_tp, sk_pc, br_tp, br_pc;
  logic [31:0] rd;
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;
  // Words sit on and next to the plus and minus one boundaries of each half
  logic [31:0] wtab [8] = '{32'h0001ffff, 32'hffff0001, 32'h00010001, 32'hffffffff,
                            32'h00000000, 32'h01000100, 32'hfffe0001, 32'h0001fffe};
  logic [3:0] ztab [8] = '{4'hf, 4'h3, 4'hc, 4'h0, 4'h5, 4'ha, 4'h1, 4'he};
  logic [3:0] ntab [8] = '{4'h0, 4'h1, 4'h4, 4'h0, 4'ha, 4'h4, 4'he, 4'h1};

  ssb_decode_model i_ssb_decode_model (.op_i(op), .step2_i(step), .lines_o(dl));

  ssb_top i_ssb_top (.sys_clk_i(clk), .rst_b_i(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .exec_step2_i(step), .pull_stack_i(dl[0]), .push_stack_i(dl[1]), .modify_stack_i(dl[2]),
    .sub_one_branch_if_zero_i(dl[3]), .sub_one_branch_unless_zero_i(dl[4]),
    .add_one_branch_if_zero_i(dl[5]), .add_one_branch_unless_zero_i(dl[6]),
    .byte_positive_branch_i(dl[7]), .half_negative_branch_i(dl[8]), .half_positive_branch_i(dl[9]),
    .word_negative_branch_i(dl[10]), .word_positive_branch_i(dl[11]), .word_nonzero_branch_i(dl[12]),
    .half_nonzero_branch_i(dl[13]), .word_zero_branch_i(dl[14]), .half_zero_branch_i(dl[15]),
    .byte_nonzero_branch_i(dl[16]), .byte_zero_branch_i(dl[17]), .byte_negative_branch_i(dl[18]),
    .left_half_select_i(lh), .right_half_select_i(rh), .byte_select_i(bsel), .byte_zero_flag_i(zf),
    .byte_sign_negative_flag_i(nf), .byte_positive_flag_i(pf), .vpr_word_i(word),
    .stack_skip_n_tp_o(sk_tp), .stack_skip_n_pc_o(sk_pc), .branch_taken_n_tp_o(br_tp),
    .branch_taken_n_pc_o(br_pc));

  // Free-running system clock
  initial begin
    forever #10 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Cuts a hung handshake short; the run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      $display("Error timeout expected finish seen hang");
      report_and_stop();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Classic single cycle; request held until ack is sampled high
  task automatic wb_io(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb_io

  // Reference decision worked out from the test flags; returns skip_n and branch_n
  function automatic logic [1:0] expected(input logic [4:0] o, input logic s);
    logic p1l, p1r, m1l, m1r, t, sk;
    p1l = word[31:16] == 16'h0001;
    p1r = word[15:0] == 16'h0001;
    m1l = word[31:16] == 16'hffff;
    m1r = word[15:0] == 16'hffff;
    case (o)
      5'h03: t = (lh & p1l) | (rh & p1r);
      5'h04: t = (lh & !p1l) | (rh & !p1r);
      5'h05: t = (lh & m1l) | (rh & m1r);
      5'h06: t = (lh & !m1l) | (rh & !m1r);
      5'h07: t = |(bsel & pf);
      5'h08: t = (lh & nf[0]) | (rh & nf[2]);
      5'h09: t = (lh & pf[0]) | (rh & pf[2]);
      5'h0a: t = nf[0];
      5'h0b: t = pf[0];
      5'h0c: t = !(&zf);
      5'h0d: t = (lh & !(zf[0] & zf[1])) | (rh & !(zf[2] & zf[3]));
      5'h0e: t = &zf;
      5'h0f: t = (lh & zf[0] & zf[1]) | (rh & zf[2] & zf[3]);
      5'h10: t = |(bsel & ~zf);
      5'h11: t = |(bsel & zf);
      5'h12: t = |(bsel & nf);
      default: t = 1'b0;
    endcase
    sk = 1'b1;
    if (o == 5'h00) sk = zf[0] & zf[1];
    if (o == 5'h01) sk = zf[2] & zf[3];
    if (o == 5'h02) sk = nf[0] | nf[2];
    return (s && en) ? {sk, !t} : 2'h3;
  endfunction : expected

  task automatic check_out(input logic [1:0] e);
    chk("skip_tp", {31'h0, sk_tp}, {31'h0, e[1]});
    chk("skip_pc", {31'h0, sk_pc}, {31'h0, e[1]});
    chk("branch_tp", {31'h0, br_tp}, {31'h0, e[0]});
    chk("branch_pc", {31'h0, br_pc}, {31'h0, e[0]});
  endtask : check_out

  // Holds one decode case for a cycle, then checks the registered outputs
  task automatic apply(input logic [4:0] o, input logic s, input int k);
    @(posedge clk);
    op <= o;
    step <= s;
    lh <= k[0];
    rh <= !k[0];
    bsel <= 4'h1 << k[1:0];
    zf <= ztab[k];
    nf <= ntab[k];
    pf <= ~(ztab[k] | ntab[k]);
    word <= wtab[k];
    @(posedge clk);
    @(negedge clk);
    check_out(expected(o, s));
  endtask : apply

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    check_out(2'h3);
    rst_b <= 1'b1;
    wb_io(1'b0, ssb_pkg::CTRL_OFS, 32'h0);
    chk("ctrl_rst", rd, 32'h1);
    wb_io(1'b0, ssb_pkg::SKCNT_OFS, 32'h0);
    chk("skip_cnt_rst", rd, 32'h0);
    $display("test reset done");
    for (int o = 0; o < 19; o++) begin
      for (int k = 0; k < 8; k++) begin
        apply(o[4:0], k != 7, k);
      end
    end
    $display("test decode table done");
    @(posedge clk);
    op <= 5'h00;
    step <= 1'b1;
    zf <= 4'h0;
    wb_io(1'b0, ssb_pkg::STAT_OFS, 32'h0);
    chk("status", rd, 32'h2);
    op <= 5'h1f;
    wb_io(1'b1, ssb_pkg::CTRL_OFS, 32'h3);
    op <= 5'h00;
    repeat (5) @(posedge clk);
    op <= 5'h1f;
    wb_io(1'b0, ssb_pkg::SKCNT_OFS, 32'h0);
    chk("skip_cnt", rd, 32'h5);
    wb_io(1'b0, ssb_pkg::BRCNT_OFS, 32'h0);
    chk("branch_cnt", rd, 32'h0);
    $display("test status and counters done");
    wb_io(1'b1, ssb_pkg::CTRL_OFS, 32'h0);
    en = 1'b0;
    for (int o = 0; o < 19; o++) begin
      apply(o[4:0], 1'b1, 3);
    end
    en = 1'b1;
    wb_io(1'b1, ssb_pkg::CTRL_OFS, 32'h1);
    apply(5'h00, 1'b1, 3);
    $display("test disable done");
    wb_io(1'b1, 4'h2, 32'hffffffff);
    wb_io(1'b0, 4'h2, 32'h0);
    chk("unmapped", rd, 32'h0);
    wb_io(1'b0, ssb_pkg::CTRL_OFS, 32'h0);
    chk("ctrl_kept", rd, 32'h1);
    $display("test unmapped done");
    report_and_stop();
  end
endmodule : ssb_top_tb
`default_nettype wire
